// *** design/qom_consts.svh ***
// constants of the queued output match channel
`ifndef QOM_CONSTS_SVH
`define QOM_CONSTS_SVH

`define QOM_TBL_DEPTH      8
`define QOM_TIME_W         16
`define QOM_LOOP_W         8

// register byte offsets
`define QOM_REG_CTRL       8'h00
`define QOM_REG_HSR        8'h04
`define QOM_REG_LOOPCNT    8'h08
`define QOM_REG_REFADDR    8'h0C
`define QOM_REG_TBLLEN     8'h10
`define QOM_REG_STATUS     8'h14
`define QOM_REG_CLEAR      8'h18
`define QOM_REG_IEN        8'h1C
`define QOM_REG_INFO       8'h20
`define QOM_REG_LASTTIME   8'h24
`define QOM_REG_MATCHTIME  8'h28
`define QOM_REG_TBL_BASE   8'h40

// control register fields, and the edge bit of a table entry
`define QOM_CTRL_SEQ_LSB   0
`define QOM_CTRL_PRIO_LSB  2
`define QOM_CTRL_TBSEL     4
`define QOM_CTRL_LINK      5
`define QOM_CTRL_REF_LSB   6
`define QOM_TBL_EDGE       16

// codes
`define QOM_SEQ_SINGLE     2'h0
`define QOM_SEQ_LOOP       2'h1
`define QOM_HSR_NONE       2'h0
`define QOM_HSR_INIT_KEEP  2'h1
`define QOM_HSR_INIT_LOW   2'h2
`define QOM_HSR_INIT_HIGH  2'h3
`define QOM_PRIO_OFF       2'h0
`define QOM_REF_NOW        2'h0
`define QOM_REF_PTR        2'h2

// interrupt event bits
`define QOM_EV_DONE        0
`define QOM_EV_MATCH       1
`define QOM_EV_W           2

`endif

// *** design/qom_pkg.sv ***
// types of the queued output match channel
`include "qom_consts.svh"

package qom_pkg;

  localparam int IDX_W = $clog2(`QOM_TBL_DEPTH);
  localparam int LEN_W = $clog2(`QOM_TBL_DEPTH + 1);

  typedef enum logic [1:0] {
    QOM_IDLE,
    QOM_WAIT_LINK,
    QOM_RUN
  } qom_state_e;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } qom_sync_s;

  typedef struct packed {
    qom_state_e                                  state;
    logic [1:0]                                  hostSeq;
    logic [1:0]                                  prio;
    logic [1:0]                                  hsr;
    logic [1:0]                                  refSel;
    logic                                        tbSel;
    logic                                        linkStart;
    logic [`QOM_LOOP_W-1:0]                      loopCount;
    logic [`QOM_LOOP_W-1:0]                      loopsLeft;
    logic [`QOM_TIME_W-1:0]                      refAddr;
    logic [`QOM_TIME_W-1:0]                      lastTime;
    logic [`QOM_TIME_W-1:0]                      matchTime;
    logic [IDX_W-1:0]                            idx;
    logic [LEN_W-1:0]                            tblLen;
    logic [`QOM_TBL_DEPTH-1:0][`QOM_TIME_W:0]    tbl;
    logic [`QOM_EV_W-1:0]                        status;
    logic [`QOM_EV_W-1:0]                        ien;
    logic                                        pin;
    logic                                        linkPrev;
    logic                                        ack;
    logic [31:0]                                 rdData;
  } qom_regs_s;

endpackage : qom_pkg

// *** design/qom_sync3.sv ***
// three-stage synchroniser with agreement filter
`timescale 1ns/100ps
`include "qom_consts.svh"

module qom_sync3 (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);

  qom_pkg::qom_sync_s cur;
  qom_pkg::qom_sync_s next_st;

  always_comb begin
    next_st    = cur;
    next_st.s1 = din;
    next_st.s2 = cur.s1;
    next_st.s3 = cur.s2;
    // level moves only when the two later stages agree
    if (cur.s2 == cur.s3) begin
      next_st.level = cur.s3;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_st;
    end
  end

  assign dout = cur.level;

endmodule : qom_sync3

// *** design/qom_channel.sv ***
// queued output match channel with wishbone register slave
// Notes on behaviour
// - the channel makes match events one after another, each timed by the next entry of the offset table.
// - the train runs once, a set number of passes, or without end, as the loop behaviour selects.
// - the channel can hold its start until a link pulse from another channel arrives.
// - the first-match base can be a time supplied by another channel.
// - high time can be anywhere from zero to the whole period, both ends included.
// - the channel can serve as a discrete output set to a fixed level on host request.
// - timebase bit 0 picks the primary timebase counter and 1 the secondary one.
// - the edge bit of a match drives the pin high when 1 and low when 0.
// - reference 00 is the current count, 01 or 11 the last event time, 10 the value at the reference pointer.
// - host sequence 00 is single shot, 01 counted loop, 10 or 11 continuous.
// - service codes 01, 10, 11 initialise with pin kept, pin low, pin high.
// - service code 00 means nothing pending and is the value after reset.
// - priority 00 disables the channel, 01 to 11 give low, medium and high priority; the channel treats 01, 10 and 11 alike.
// - the interrupt enable passes the channel's requests to the host when 1 and blocks them when 0.
// - the interrupt status reads 1 while the channel has a request pending.
`timescale 1ns/100ps
`include "qom_consts.svh"

module qom_channel (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [15:0] primary_timebase_counter,
  input  wire logic [15:0] secondary_timebase_counter,
  input  wire logic        linkIn,
  input  wire logic [15:0] refData,
  output logic      [15:0] refAddr,
  output logic             chPin,
  output logic             irq
);

  localparam int IW = qom_pkg::IDX_W;
  localparam int LW = qom_pkg::LEN_W;
  localparam int TW = `QOM_TIME_W;

  qom_pkg::qom_regs_s cur;
  qom_pkg::qom_regs_s next_st;

  logic                 linkLevel;
  logic                 linkRise;
  logic [TW-1:0]        tbNow;
  logic [TW:0]          entry;
  logic [IW-1:0]        nextIdx;
  logic                 lastEntry;
  logic [TW-1:0]        startBase;
  logic [31:0]          rdMux;
  logic [31:0]          wrMask;
  logic [31:0]          oldVal;
  logic [31:0]          newVal;
  logic                 busReq;
  logic                 busWrite;
  logic                 isTbl;
  logic [IW-1:0]        tblIdx;
  logic [`QOM_EV_W-1:0] events;
  logic [`QOM_EV_W-1:0] clrMask;
  logic                 doStart;
  logic                 matchHit;

  qom_sync3 u_linkSync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .din      (linkIn),
    .dout     (linkLevel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  assign busReq   = wb_cyc_i & wb_stb_i;
  assign busWrite = busReq & wb_we_i & cur.ack;
  assign isTbl    = (wb_adr_i >= `QOM_REG_TBL_BASE) &&
                    (wb_adr_i < 8'(`QOM_REG_TBL_BASE + 4 * `QOM_TBL_DEPTH));
  assign tblIdx   = IW'((wb_adr_i - `QOM_REG_TBL_BASE) >> 2);
  assign wrMask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign newVal   = (oldVal & ~wrMask) | (wb_dat_i & wrMask);
  assign tbNow    = cur.tbSel ? secondary_timebase_counter : primary_timebase_counter;
  assign linkRise = linkLevel & ~cur.linkPrev;
  assign entry    = cur.tbl[cur.idx];
  assign lastEntry = (LW'(cur.idx) == LW'(cur.tblLen - LW'(1)));
  assign nextIdx  = lastEntry ? '0 : IW'(cur.idx + IW'(1));
  assign matchHit = (cur.prio != `QOM_PRIO_OFF) && (cur.hsr == `QOM_HSR_NONE) &&
                    (cur.state == qom_pkg::QOM_RUN) && (tbNow == cur.matchTime);

  always_comb begin
    case (cur.refSel)
      `QOM_REF_NOW: startBase = tbNow;
      `QOM_REF_PTR: startBase = refData;
      default:      startBase = cur.lastTime;
    endcase
  end

  always_comb begin
    rdMux = 32'h0;
    if (isTbl) begin
      rdMux = 32'(cur.tbl[tblIdx]);
    end else begin
      case (wb_adr_i)
        `QOM_REG_CTRL: rdMux = 32'({cur.refSel, cur.linkStart, cur.tbSel, cur.prio, cur.hostSeq});
        `QOM_REG_HSR:       rdMux = 32'(cur.hsr);
        `QOM_REG_LOOPCNT:   rdMux = 32'(cur.loopCount);
        `QOM_REG_REFADDR:   rdMux = 32'(cur.refAddr);
        `QOM_REG_TBLLEN:    rdMux = 32'(cur.tblLen);
        `QOM_REG_STATUS:    rdMux = 32'(cur.status);
        `QOM_REG_IEN:       rdMux = 32'(cur.ien);
        `QOM_REG_INFO:      rdMux = {8'h0, cur.loopsLeft, 8'(cur.idx), 5'h0, cur.pin, cur.state};
        `QOM_REG_LASTTIME:  rdMux = 32'(cur.lastTime);
        `QOM_REG_MATCHTIME: rdMux = 32'(cur.matchTime);
        default:            rdMux = 32'h0;
      endcase
    end
  end

  always_comb begin
    oldVal = rdMux;
    if (wb_adr_i == `QOM_REG_CLEAR) begin
      oldVal = 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer, registers, interrupts
  always_comb begin
    next_st          = cur;
    events           = '0;
    clrMask          = '0;
    doStart          = 1'b0;
    next_st.linkPrev = linkLevel;
    next_st.ack      = busReq & ~cur.ack;
    if (busReq & ~cur.ack) begin
      next_st.rdData = rdMux;
    end

    if (cur.prio == `QOM_PRIO_OFF) begin
      next_st.state = qom_pkg::QOM_IDLE;
    end else if (cur.hsr != `QOM_HSR_NONE) begin
      next_st.hsr       = `QOM_HSR_NONE;
      next_st.idx       = '0;
      next_st.loopsLeft = cur.loopCount;
      case (cur.hsr)
        `QOM_HSR_INIT_LOW:  next_st.pin = 1'b0;
        `QOM_HSR_INIT_HIGH: next_st.pin = 1'b1;
        default:            next_st.pin = cur.pin;
      endcase
      if (cur.tblLen == '0) begin
        next_st.state = qom_pkg::QOM_IDLE;
      end else if (cur.linkStart) begin
        next_st.state = qom_pkg::QOM_WAIT_LINK;
      end else begin
        doStart = 1'b1;
      end
    end else begin
      case (cur.state)
        qom_pkg::QOM_WAIT_LINK: begin
          if (linkRise) begin
            doStart = 1'b1;
          end
        end
        qom_pkg::QOM_RUN: begin
          if (tbNow == cur.matchTime) begin
            next_st.pin              = entry[`QOM_TBL_EDGE];
            next_st.lastTime         = cur.matchTime;
            events[`QOM_EV_MATCH]    = 1'b1;
            next_st.idx              = nextIdx;
            next_st.matchTime        = TW'(cur.matchTime + cur.tbl[nextIdx][TW-1:0]);
            if (lastEntry) begin
              case (cur.hostSeq)
                `QOM_SEQ_SINGLE: begin
                  next_st.state         = qom_pkg::QOM_IDLE;
                  events[`QOM_EV_DONE]  = 1'b1;
                end
                `QOM_SEQ_LOOP: begin
                  if (cur.loopsLeft <= `QOM_LOOP_W'(1)) begin
                    next_st.state        = qom_pkg::QOM_IDLE;
                    events[`QOM_EV_DONE] = 1'b1;
                  end else begin
                    next_st.loopsLeft = cur.loopsLeft - `QOM_LOOP_W'(1);
                  end
                end
                default: next_st.state = qom_pkg::QOM_RUN;
              endcase
            end
          end
        end
        default: next_st.state = qom_pkg::QOM_IDLE;
      endcase
    end

    if (doStart) begin
      next_st.state     = qom_pkg::QOM_RUN;
      next_st.idx       = '0;
      next_st.matchTime = TW'(startBase + cur.tbl[0][TW-1:0]);
    end

    if (busWrite) begin
      if (isTbl) begin
        next_st.tbl[tblIdx] = newVal[TW:0];
      end else begin
        case (wb_adr_i)
          `QOM_REG_CTRL: begin
            next_st.hostSeq   = newVal[`QOM_CTRL_SEQ_LSB +: 2];
            next_st.prio      = newVal[`QOM_CTRL_PRIO_LSB +: 2];
            next_st.tbSel     = newVal[`QOM_CTRL_TBSEL];
            next_st.linkStart = newVal[`QOM_CTRL_LINK];
            next_st.refSel    = newVal[`QOM_CTRL_REF_LSB +: 2];
          end
          `QOM_REG_HSR:     next_st.hsr       = newVal[1:0];
          `QOM_REG_LOOPCNT: next_st.loopCount = newVal[`QOM_LOOP_W-1:0];
          `QOM_REG_REFADDR: next_st.refAddr   = newVal[TW-1:0];
          `QOM_REG_TBLLEN:  next_st.tblLen    = (newVal[LW-1:0] > LW'(`QOM_TBL_DEPTH)) ?
                                                LW'(`QOM_TBL_DEPTH) : newVal[LW-1:0];
          `QOM_REG_CLEAR:   clrMask           = newVal[`QOM_EV_W-1:0];
          `QOM_REG_IEN:     next_st.ien       = newVal[`QOM_EV_W-1:0];
          default:          next_st.ien       = cur.ien;
        endcase
      end
    end

    // a new event beats a clear in the same cycle
    next_st.status = (cur.status & ~clrMask) | events;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_st;
    end
  end

  assign wb_dat_o = cur.rdData;
  assign wb_ack_o = cur.ack;
  assign refAddr  = cur.refAddr;
  assign chPin    = cur.pin;
  assign irq      = |(cur.status & cur.ien);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_hsrIdle;
    @(posedge core_clk) !rst_n |=> (cur.hsr == `QOM_HSR_NONE) && (cur.state == qom_pkg::QOM_IDLE);
  endproperty
  a_hsrIdle: assert property (p_hsrIdle) else $error("service field not idle after reset");

  property p_initLow;
    @(posedge core_clk) disable iff (!rst_n)
      (cur.prio != `QOM_PRIO_OFF && cur.hsr == `QOM_HSR_INIT_LOW) |=> !chPin && cur.hsr == `QOM_HSR_NONE;
  endproperty
  a_initLow: assert property (p_initLow) else $error("init low did not drive pin low");

  property p_initHigh;
    @(posedge core_clk) disable iff (!rst_n)
      (cur.prio != `QOM_PRIO_OFF && cur.hsr == `QOM_HSR_INIT_HIGH) |=> chPin;
  endproperty
  a_initHigh: assert property (p_initHigh) else $error("init high did not drive pin high");

  property p_matchEdge;
    @(posedge core_clk) disable iff (!rst_n)
      (cur.prio != `QOM_PRIO_OFF && cur.hsr == `QOM_HSR_NONE && cur.state == qom_pkg::QOM_RUN &&
       tbNow == cur.matchTime) |=> (chPin == $past(entry[`QOM_TBL_EDGE])) && cur.status[`QOM_EV_MATCH];
  endproperty
  a_matchEdge: assert property (p_matchEdge) else $error("match edge wrong");

  property p_disabled;
    @(posedge core_clk) disable iff (!rst_n)
      (cur.prio == `QOM_PRIO_OFF) |=> cur.state == qom_pkg::QOM_IDLE && $stable(chPin);
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled channel is active");

  property p_timebase;
    @(posedge core_clk) disable iff (!rst_n)
      (cur.prio != `QOM_PRIO_OFF && cur.hsr == `QOM_HSR_NONE && cur.state == qom_pkg::QOM_RUN && cur.tbSel &&
       secondary_timebase_counter == cur.matchTime)
      |=> cur.lastTime == $past(secondary_timebase_counter) && cur.status[`QOM_EV_MATCH];
  endproperty
  a_timebase: assert property (p_timebase) else $error("wrong timebase selected");

  property p_irqMask;
    @(posedge core_clk) disable iff (!rst_n)
      (cur.status[`QOM_EV_DONE] && cur.ien[`QOM_EV_DONE]) |-> irq;
  endproperty
  a_irqMask: assert property (p_irqMask) else $error("enabled request not on irq");

  property p_singleDone;
    @(posedge core_clk) disable iff (!rst_n)
      (cur.prio != `QOM_PRIO_OFF && cur.hsr == `QOM_HSR_NONE && cur.state == qom_pkg::QOM_RUN &&
       tbNow == cur.matchTime && lastEntry && cur.hostSeq == `QOM_SEQ_SINGLE)
      |=> cur.state == qom_pkg::QOM_IDLE ##1 cur.status[`QOM_EV_DONE];
  endproperty
  a_singleDone: assert property (p_singleDone) else $error("single shot did not finish");

  property p_refNow;
    @(posedge core_clk) disable iff (!rst_n)
      doStart && cur.refSel == `QOM_REF_NOW |=> cur.matchTime == TW'($past(tbNow) + $past(cur.tbl[0][TW-1:0]));
  endproperty
  a_refNow: assert property (p_refNow) else $error("first match base wrong");

  property p_linkStart;
    @(posedge core_clk) disable iff (!rst_n)
      (cur.prio != `QOM_PRIO_OFF && cur.hsr == `QOM_HSR_NONE && cur.state == qom_pkg::QOM_WAIT_LINK && linkRise)
      |=> cur.state == qom_pkg::QOM_RUN;
  endproperty
  a_linkStart: assert property (p_linkStart) else $error("link did not start sequence");

  property p_refPtr;
    @(posedge core_clk) disable iff (!rst_n)
      doStart && cur.refSel == `QOM_REF_PTR
      |=> cur.matchTime == TW'($past(refData) + $past(cur.tbl[0][TW-1:0]));
  endproperty
  a_refPtr: assert property (p_refPtr) else $error("pointed reference not used");

  property p_loopNext;
    @(posedge core_clk) disable iff (!rst_n)
      matchHit && lastEntry && cur.hostSeq == `QOM_SEQ_LOOP && cur.loopsLeft > 8'h01
      |=> cur.state == qom_pkg::QOM_RUN && cur.loopsLeft == $past(cur.loopsLeft) - 8'h01;
  endproperty
  a_loopNext: assert property (p_loopNext) else $error("loop pass not counted");

  property p_loopEnd;
    @(posedge core_clk) disable iff (!rst_n)
      matchHit && lastEntry && cur.hostSeq == `QOM_SEQ_LOOP && cur.loopsLeft <= 8'h01
      |=> cur.state == qom_pkg::QOM_IDLE && cur.status[`QOM_EV_DONE];
  endproperty
  a_loopEnd: assert property (p_loopEnd) else $error("loop did not finish");

  property p_continuous;
    @(posedge core_clk) disable iff (!rst_n)
      matchHit && lastEntry && cur.hostSeq[1]
      |=> cur.state == qom_pkg::QOM_RUN && cur.idx == '0;
  endproperty
  a_continuous: assert property (p_continuous) else $error("continuous train stopped");

  property p_keepPin;
    @(posedge core_clk) disable iff (!rst_n)
      cur.prio != `QOM_PRIO_OFF && cur.hsr == `QOM_HSR_INIT_KEEP
      |=> $stable(chPin);
  endproperty
  a_keepPin: assert property (p_keepPin) else $error("init without pin change moved the pin");

  property p_doneSticky;
    @(posedge core_clk) disable iff (!rst_n)
      cur.status[`QOM_EV_DONE] && !(busReq && wb_we_i && wb_adr_i == `QOM_REG_CLEAR)
      |=> cur.status[`QOM_EV_DONE];
  endproperty
  a_doneSticky: assert property (p_doneSticky) else $error("status bit lost without clear");

  property p_discrete;
    @(posedge core_clk) disable iff (!rst_n)
      cur.prio != `QOM_PRIO_OFF && cur.hsr != `QOM_HSR_NONE && cur.tblLen == '0
      |=> cur.state == qom_pkg::QOM_IDLE;
  endproperty
  a_discrete: assert property (p_discrete) else $error("discrete output started a sequence");

endmodule : qom_channel

// *** verif/qom_far_side.sv ***
// model of the circuitry around the channel: pin watcher, link source, reference memory
`timescale 1ns/100ps

module qom_far_side (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        chPin,
  input  wire logic [15:0] refAddr,
  input  wire logic        fireLink,
  output logic      [15:0] refData,
  output logic             linkIn,
  output logic      [15:0] riseCount,
  output logic      [15:0] fallCount
);
  logic [3:0] linkLeft;
  logic       pinPrev;

  // reference time held by another channel
  assign refData = refAddr + 16'h0100;
  // link held long enough to pass the filter
  assign linkIn = (linkLeft != 4'h0);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      linkLeft  <= 4'h0;
      pinPrev   <= 1'b0;
      riseCount <= 16'h0000;
      fallCount <= 16'h0000;
    end else begin
      pinPrev <= chPin;
      if (chPin && !pinPrev) begin
        riseCount <= riseCount + 16'h0001;
      end
      if (!chPin && pinPrev) begin
        fallCount <= fallCount + 16'h0001;
      end
      if (fireLink) begin
        linkLeft <= 4'h8;
      end else if (linkLeft != 4'h0) begin
        linkLeft <= linkLeft - 4'h1;
      end
    end
  end
endmodule : qom_far_side

// *** verif/qom_channel_bench.sv ***
// self-checking bench of the queued output match channel
`timescale 1ns/100ps
`include "qom_consts.svh"

module qom_channel_bench;
  logic        coreClk  = 1'b0;
  logic        rstN     = 1'b0;
  logic        wbCyc    = 1'b0;
  logic        wbStb    = 1'b0;
  logic        wbWe     = 1'b0;
  logic [7:0]  wbAdr    = 8'h00;
  logic [3:0]  wbSel    = 4'hF;
  logic [31:0] wbDat    = 32'h0;
  logic        fireLink = 1'b0;
  logic        tb2Run   = 1'b0;
  logic [15:0] tb1      = 16'h0000;
  logic [15:0] tb2      = 16'h0000;
  logic [15:0] rise0    = 16'h0000;
  logic [15:0] fall0    = 16'h0000;
  logic [31:0] wbDatO, rd;
  logic        wbAck, chPin, irq, linkIn;
  logic [15:0] refAddr, refData, riseCount, fallCount;
  logic [1:0]  codes [3] = '{2'h1, 2'h2, 2'h1};
  logic        pins  [3] = '{1'b1, 1'b0, 1'b0};
  int          failures       = 0;
  int          samplesChecked = 0;

  always #25 coreClk = ~coreClk;

  always @(posedge coreClk) begin
    tb1 <= tb1 + 16'h0001;
    if (tb2Run) begin
      tb2 <= tb2 + 16'h0001;
    end
  end

  qom_channel qom_channel_i (.core_clk(coreClk), .rst_n(rstN), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .primary_timebase_counter(tb1), .secondary_timebase_counter(tb2),
    .linkIn(linkIn), .refData(refData), .refAddr(refAddr), .chPin(chPin), .irq(irq));

  qom_far_side qom_far_side_i (.core_clk(coreClk), .rst_n(rstN), .chPin(chPin), .refAddr(refAddr),
    .fireLink(fireLink), .refData(refData), .linkIn(linkIn), .riseCount(riseCount), .fallCount(fallCount));

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (failures == 0 && samplesChecked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [31:0] expv, input logic [31:0] got);
    samplesChecked++;
    if (got !== expv) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, expv, got);
    end
  endtask : check

  task automatic checkBit(input string what, input logic expv, input logic got);
    check(what, {31'h0, expv}, {31'h0, got});
  endtask : checkBit

  // classic single cycle, held until ack is sampled high
  task automatic wbXfer(input logic [7:0] a, input logic we, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge coreClk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe  <= we;
    wbAdr <= a;
    wbDat <= d;
    do begin
      @(posedge coreClk);
      n++;
    end while (wbAck !== 1'b1);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
    check("ack latency", 32'h2, n);
  endtask : wbXfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wbXfer(a, 1'b1, d);
  endtask : wr

  task automatic rdChk(input logic [7:0] a, input logic [31:0] expv, input string what);
    wbXfer(a, 1'b0, 32'h0);
    check(what, expv, rd);
  endtask : rdChk

  task automatic stateChk(input logic [1:0] expv);
    wbXfer(`QOM_REG_INFO, 1'b0, 32'h0);
    check("channel state", {30'h0, expv}, {30'h0, rd[1:0]});
  endtask : stateChk

  task automatic edges(input logic [15:0] r, input logic [15:0] f);
    check("rising edges", {16'h0, r}, {16'h0, riseCount - rise0});
    check("falling edges", {16'h0, f}, {16'h0, fallCount - fall0});
    rise0 = riseCount;
    fall0 = fallCount;
  endtask : edges

  task automatic waitDone;
    int n;
    n = 0;
    do begin
      wbXfer(`QOM_REG_STATUS, 1'b0, 32'h0);
      n++;
    end while (rd[`QOM_EV_DONE] !== 1'b1 && n < 1000);
    checkBit("sequence done", 1'b1, rd[`QOM_EV_DONE]);
  endtask : waitDone

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(50 * 40000);
    failures++;
    end_of_test();
  end

  initial begin
    logic e;
    repeat (3) @(posedge coreClk);
    rstN <= 1'b1;
    rdChk(`QOM_REG_HSR, 32'h0, "service after reset");
    rdChk(`QOM_REG_STATUS, 32'h0, "status after reset");
    rdChk(8'h3C, 32'h0, "unmapped read");
    // discrete output, first with the channel disabled
    wr(`QOM_REG_TBLLEN, 32'h0);
    wr(`QOM_REG_HSR, 32'h3);
    rdChk(`QOM_REG_HSR, 32'h3, "service pending while off");
    checkBit("pin while off", 1'b0, chPin);
    wr(`QOM_REG_CTRL, 32'h04);
    repeat (3) @(posedge coreClk);
    checkBit("discrete high", 1'b1, chPin);
    rdChk(`QOM_REG_HSR, 32'h0, "service consumed");
    foreach (codes[i]) begin
      wr(`QOM_REG_HSR, {30'h0, codes[i]});
      repeat (3) @(posedge coreClk);
      checkBit("discrete level", pins[i], chPin);
    end
    edges(16'h1, 16'h1);
    // single shot on the primary timebase from the pointed reference
    wr(`QOM_REG_REFADDR, 32'h0400);
    wr(`QOM_REG_TBL_BASE, 32'h10014);
    wr(`QOM_REG_TBL_BASE + 8'h04, 32'h0001E);
    wr(`QOM_REG_TBLLEN, 32'h2);
    wr(`QOM_REG_CTRL, 32'h84);
    wr(`QOM_REG_HSR, 32'h2);
    waitDone();
    rdChk(`QOM_REG_LASTTIME, 32'h0532, "single shot last time");
    edges(16'h1, 16'h1);
    stateChk(2'h0);
    checkBit("irq masked", 1'b0, irq);
    wr(`QOM_REG_IEN, 32'h3);
    repeat (2) @(posedge coreClk);
    checkBit("irq enabled", 1'b1, irq);
    wr(`QOM_REG_CLEAR, 32'h3);
    rdChk(`QOM_REG_STATUS, 32'h0, "status cleared");
    checkBit("irq cleared", 1'b0, irq);
    wr(`QOM_REG_IEN, 32'h0);
    // secondary timebase, primary far ahead of the match times
    wr(`QOM_REG_REFADDR, 32'h0200);
    wr(`QOM_REG_CTRL, 32'h94);
    tb2Run <= 1'b1;
    wr(`QOM_REG_HSR, 32'h1);
    waitDone();
    rdChk(`QOM_REG_LASTTIME, 32'h0332, "secondary last time");
    edges(16'h1, 16'h1);
    // counted loop from the last event time
    wr(`QOM_REG_TBL_BASE, 32'h10100);
    wr(`QOM_REG_TBL_BASE + 8'h04, 32'h00010);
    wr(`QOM_REG_LOOPCNT, 32'h3);
    wr(`QOM_REG_CLEAR, 32'h3);
    wr(`QOM_REG_CTRL, 32'h55);
    wr(`QOM_REG_HSR, 32'h1);
    waitDone();
    rdChk(`QOM_REG_LASTTIME, 32'h0662, "loop last time");
    edges(16'h3, 16'h3);
    // continuous modes, full and empty high time
    for (int s = 2; s < 4; s++) begin
      e = (s == 2);
      wr(`QOM_REG_TBL_BASE, {15'h0, e, 16'h0008});
      wr(`QOM_REG_TBL_BASE + 8'h04, {15'h0, e, 16'h0008});
      wr(`QOM_REG_CLEAR, 32'h3);
      wr(`QOM_REG_CTRL, 32'h04 | s);
      wr(`QOM_REG_HSR, e ? 32'h2 : 32'h3);
      repeat (100) @(posedge coreClk);
      stateChk(2'h2);
      rdChk(`QOM_REG_STATUS, 32'h2, "continuous status");
      checkBit("duty extreme", e, chPin);
      edges({15'h0, e}, {15'h0, !e});
      wr(`QOM_REG_CTRL, s);
      stateChk(2'h0);
    end
    // start held until a link arrives
    wr(`QOM_REG_TBLLEN, 32'h1);
    wr(`QOM_REG_TBL_BASE, 32'h10008);
    wr(`QOM_REG_CTRL, 32'h24);
    wr(`QOM_REG_HSR, 32'h2);
    repeat (20) @(posedge coreClk);
    stateChk(2'h1);
    checkBit("pin before link", 1'b0, chPin);
    fireLink <= 1'b1;
    @(posedge coreClk);
    fireLink <= 1'b0;
    waitDone();
    checkBit("pin after link", 1'b1, chPin);
    edges(16'h1, 16'h0);
    end_of_test();
  end
endmodule : qom_channel_bench
